//--- bench/mcu_model.sv
`timescale 1ns/1ns
module mcu_model (
    input wire logic REF_CLK_IN,
    output logic SERVICE_N_OUT
);
    // the controller drives the clear line push-pull, idle high between pulses
    initial begin
        SERVICE_N_OUT = 1'h1;
    end
    // one active-low clear pulse, launched n falling edges from now
    task automatic pulse_after(input int n);
        repeat (n) @(negedge REF_CLK_IN);
        SERVICE_N_OUT = 1'h0;
        repeat (4) @(negedge REF_CLK_IN);
        SERVICE_N_OUT = 1'h1;
    endtask
endmodule

//--- bench/windowed_watchdog_supervisor_tb.sv
`timescale 1ns/1ns
module windowed_watchdog_supervisor_tb;
    // short tick so that one millisecond lasts 4 cycles
    localparam int DIV = 4;
    logic ref_clk, rst, level, service_n, oe, data_n, permit_n, standby, w_oe, s_oe, s_standby;
    int num_errors = 0;
    int n_compared = 0;
    // clock and time-zero values
    initial begin
        ref_clk = 1'h0;
        rst = 1'h1;
        level = 1'h1;
        forever #4 ref_clk = ~ref_clk;
    end
    mcu_model mcu_model_inst (.REF_CLK_IN(ref_clk), .SERVICE_N_OUT(service_n));
    windowed_watchdog_supervisor #(.TICK_DIV(DIV)) windowed_watchdog_supervisor_inst (
        .REF_CLK_IN(ref_clk), .RST_IN(rst), .MONITORED_LEVEL_IN(level),
        .WINDOW_SERVICE_N_IN(service_n), .SYSTEM_RESTART_N_OUT(data_n),
        .SYSTEM_RESTART_N_OE_OUT(oe), .ARM_PERMIT_N_OUT(permit_n), .STANDBY_OUT(standby));
    // wide-open variant shares every input, so one early pulse compares both splits
    windowed_watchdog_supervisor #(.TICK_DIV(DIV), .WIDE_OPEN_VARIANT(1'b1))
        windowed_watchdog_supervisor_inst2 (
        .REF_CLK_IN(ref_clk), .RST_IN(rst), .MONITORED_LEVEL_IN(level),
        .WINDOW_SERVICE_N_IN(service_n), .SYSTEM_RESTART_N_OUT(),
        .SYSTEM_RESTART_N_OE_OUT(w_oe), .ARM_PERMIT_N_OUT(), .STANDBY_OUT());
    // sleep variant shares every input; a silent whole period makes it stand by
    windowed_watchdog_supervisor #(.TICK_DIV(DIV), .SLEEP_VARIANT(1'b1))
        windowed_watchdog_supervisor_inst3 (
        .REF_CLK_IN(ref_clk), .RST_IN(rst), .MONITORED_LEVEL_IN(level),
        .WINDOW_SERVICE_N_IN(service_n), .SYSTEM_RESTART_N_OUT(),
        .SYSTEM_RESTART_N_OE_OUT(s_oe), .ARM_PERMIT_N_OUT(), .STANDBY_OUT(s_standby));
    task automatic chk(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // optional reset, then hold of 100 ticks must keep restart driven
    task automatic power_up(input bit do_rst);
        int i;
        if (do_rst) begin
            rst = 1'h1;
            level = 1'h1;
            repeat (3) @(negedge ref_clk);
            rst = 1'h0;
        end
        repeat (390) @(negedge ref_clk);
        chk("restart in hold", 1'h1, oe);
        for (i = 0; i < 100 && oe !== 1'h0; i++) @(negedge ref_clk);
        chk("restart released", 1'h0, oe);
    endtask
    task automatic test_hold;
        power_up(1'b1);
        chk("open drain data", 1'h0, data_n);
        chk("permit idle", 1'h1, permit_n);
        $display("test hold done");
    endtask
    // three good services 412 cycles apart, each inside 320..476
    task automatic test_services;
        int k;
        power_up(1'b1);
        for (k = 0; k < 3; k++) begin
            chk("permit before third", 1'h1, permit_n);
            mcu_model_inst.pulse_after(400);
            repeat (8) @(negedge ref_clk);
            chk("good service", 1'h0, oe);
        end
        chk("permit granted", 1'h0, permit_n);
        $display("test services done");
    endtask
    // level drop after permit was granted
    task automatic test_brownout;
        level = 1'h0;
        repeat (2) @(negedge ref_clk);
        chk("brownout restart", 1'h1, oe);
        chk("permit dropped", 1'h1, permit_n);
        level = 1'h1;
        power_up(1'b0);
        $display("test brownout done");
    endtask
    // pulse 50 ticks into closed: early for default, open for the wide split
    task automatic test_early;
        power_up(1'b1);
        mcu_model_inst.pulse_after(200);
        repeat (8) @(negedge ref_clk);
        chk("early service", 1'h1, oe);
        chk("wide split open", 1'h0, w_oe);
        $display("test early done");
    endtask
    // no service: open window ends 119 ticks after release; the sleep variant stands by
    task automatic test_late;
        power_up(1'b1);
        repeat (440) @(negedge ref_clk);
        chk("still open", 1'h0, oe);
        repeat (60) @(negedge ref_clk);
        chk("late restart", 1'h1, oe);
        chk("no standby", 1'h0, standby);
        chk("sleep standby", 1'h1, s_standby);
        chk("sleep no restart", 1'h0, s_oe);
        mcu_model_inst.pulse_after(4);
        repeat (8) @(negedge ref_clk);
        chk("sleep wake", 1'h0, s_standby);
        $display("test late done");
    endtask
    initial begin
        test_hold();
        test_services();
        test_brownout();
        test_early();
        test_late();
        final_report();
    end
    // whole run needs about 4000 cycles; cut a hang well beyond that
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("ERROR watchdog expected done seen timeout");
        final_report();
    end
endmodule

//--- design/tick_divider.sv
`timescale 1ns/1ns
`include "wdog_params.svh"
// one-cycle enable pulse every DIV clock cycles
module tick_divider #(
    parameter int DIV = `TICK_CYCLES
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic CLEAR_IN,
    output logic TICK_OUT
);
    logic [`TICK_W-1:0] count;

    // restarted on clear so every phase starts on a whole tick
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || CLEAR_IN) begin
            count <= '0;
            TICK_OUT <= 1'b0;
        end else if (count == `TICK_W'(DIV - 1)) begin
            count <= '0;
            TICK_OUT <= 1'b1;
        end else begin
            count <= count + `TICK_W'(1);
            TICK_OUT <= 1'b0;
        end
    end
endmodule

//--- design/wdog_params.svh
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH
// time base: one tick per millisecond from the 125 MHz clock
`define CLK_PERIOD_NS 8
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
// figures in ticks (milliseconds)
`define STARTUP_HOLD_MS 100
`define WINDOW_PERIOD_MS 120
// window split in percent of the period
`define SHORT_PCT 33
`define LONG_PCT 67
// quiet time before the sleep variant stands by: one closed plus one open window
// (80 + 39 ticks); a longer span could never be reached, as a restart clears it
`define SLEEP_QUIET_MS 119
`define SERVICES_TO_PERMIT 2'h3
`define TICK_W 17
`define MS_W 9
`endif

//--- design/wdog_pkg.sv
package wdog_pkg;
    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_CLOSED = 5'h02,
        ST_OPEN = 5'h04,
        ST_FAULT = 5'h08,
        ST_SLEEP = 5'h10
    } wd_state_t;
endpackage

//--- design/windowed_watchdog_supervisor.sv
`timescale 1ns/1ns
`include "wdog_params.svh"
// Function
// [RULE1] after level returns, hold restart for the start-up time, then release
// [RULE2] restart held low whenever monitored level is below the trip reference
// [RULE3] no service before the open window ends forces a restart; the sleep variant stands by instead of restarting
// [RULE4] service during the closed window forces a restart
// [RULE5] software services only inside the open window
// [RULE6] period split 33/67 closed/open or 67/33 per variant
// [RULE7] arm permit only after three consecutive good services
// [RULE8] sleep variant stands by when the service input stays quiet
// [RULE9] arm permit is push-pull, active low
// [RULE10] restart output is open drain: drives low only, floats otherwise
// [RULE11] any restart clears service count, drops permit, restarts at closed window
// [RULE12] service input synchronised, service taken on its falling edge
module windowed_watchdog_supervisor #(
    parameter int TICK_DIV = `TICK_CYCLES,
    parameter bit WIDE_OPEN_VARIANT = 1'b0,
    parameter bit SLEEP_VARIANT = 1'b0
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic MONITORED_LEVEL_IN,
    input wire logic WINDOW_SERVICE_N_IN,
    output logic SYSTEM_RESTART_N_OUT,
    output logic SYSTEM_RESTART_N_OE_OUT,
    output logic ARM_PERMIT_N_OUT,
    output logic STANDBY_OUT
);
    localparam logic [`MS_W-1:0] CLOSED_MS = `MS_W'(`WINDOW_PERIOD_MS *
        (WIDE_OPEN_VARIANT ? `SHORT_PCT : `LONG_PCT) / 100);
    localparam logic [`MS_W-1:0] OPEN_MS = `MS_W'(`WINDOW_PERIOD_MS *
        (WIDE_OPEN_VARIANT ? `LONG_PCT : `SHORT_PCT) / 100);
    localparam logic [`MS_W-1:0] HOLD_MS = `MS_W'(`STARTUP_HOLD_MS);
    localparam logic [`MS_W-1:0] QUIET_MS = `MS_W'(`SLEEP_QUIET_MS);

    wdog_pkg::wd_state_t state;
    wdog_pkg::wd_state_t next_state;
    logic svc_meta;
    logic svc_sync;
    logic svc_prev;
    logic service;
    logic tick;
    logic phase_restart;
    logic [`MS_W-1:0] ms_count;
    logic [`MS_W-1:0] quiet_count;
    logic [1:0] good_count;
    logic level_ok;
    logic [31:0] phase_cycles;

    // two-flop synchroniser, then edge detect on the second stage only
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            svc_meta <= 1'b1;
            svc_sync <= 1'b1;
            svc_prev <= 1'b1;
        end else begin
            svc_meta <= WINDOW_SERVICE_N_IN;
            svc_sync <= svc_meta;
            svc_prev <= svc_sync;
        end
    end
    assign service = svc_prev && !svc_sync; // see [RULE12]
    assign level_ok = MONITORED_LEVEL_IN;
    assign phase_restart = (next_state != state);

    tick_divider #(
        .DIV(TICK_DIV)
    ) u_tick (
        .REF_CLK_IN(REF_CLK_IN),
        .RST_IN(RST_IN),
        .CLEAR_IN(phase_restart),
        .TICK_OUT(tick)
    );

    // window sequencer; a level drop overrides every other state
    always_comb begin
        next_state = state;
        case (state)
            wdog_pkg::ST_HOLD: begin
                if (level_ok && tick && ms_count == HOLD_MS - `MS_W'(1))
                    next_state = wdog_pkg::ST_CLOSED; // see [RULE1]
            end
            wdog_pkg::ST_CLOSED: begin
                if (service)
                    next_state = wdog_pkg::ST_FAULT; // see [RULE4]
                else if (tick && ms_count == CLOSED_MS - `MS_W'(1))
                    next_state = wdog_pkg::ST_OPEN; // see [RULE6]
            end
            wdog_pkg::ST_OPEN: begin
                if (service)
                    next_state = wdog_pkg::ST_CLOSED;
                else if (SLEEP_VARIANT && tick && quiet_count == QUIET_MS - `MS_W'(1))
                    next_state = wdog_pkg::ST_SLEEP; // see [RULE8]
                else if (tick && ms_count == OPEN_MS - `MS_W'(1))
                    next_state = wdog_pkg::ST_FAULT; // see [RULE3]
            end
            wdog_pkg::ST_FAULT: begin
                // restart pulse lasts one full period, then the hold runs again
                if (tick && ms_count == CLOSED_MS + OPEN_MS - `MS_W'(1))
                    next_state = wdog_pkg::ST_HOLD;
            end
            wdog_pkg::ST_SLEEP: begin
                if (service)
                    next_state = wdog_pkg::ST_CLOSED;
            end
            default: next_state = wdog_pkg::ST_HOLD;
        endcase
        if (!level_ok)
            next_state = wdog_pkg::ST_HOLD; // see [RULE2]
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN)
            state <= wdog_pkg::ST_HOLD;
        else
            state <= next_state;
    end

    // milliseconds spent in the current phase; held at zero while level is low
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || phase_restart || !level_ok)
            ms_count <= '0;
        else if (tick)
            ms_count <= ms_count + `MS_W'(1);
    end

    // cycles since the last phase change; the window length checks read it
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || phase_restart)
            phase_cycles <= '0;
        else
            phase_cycles <= phase_cycles + 32'h1;
    end

    // quiet time spans closed and open windows, so only a missed service sleeps
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || service || state == wdog_pkg::ST_HOLD || state == wdog_pkg::ST_FAULT)
            quiet_count <= '0;
        else if (tick && quiet_count != QUIET_MS)
            quiet_count <= quiet_count + `MS_W'(1);
    end

    // good service counter saturates at the permit count
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN || next_state == wdog_pkg::ST_HOLD || next_state == wdog_pkg::ST_FAULT)
            good_count <= 2'h0; // see [RULE11]
        else if (state == wdog_pkg::ST_OPEN && service && good_count != `SERVICES_TO_PERMIT)
            good_count <= good_count + 2'h1; // see [RULE7]
    end

    // registered pins: open-drain restart, push-pull permit
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            SYSTEM_RESTART_N_OUT <= 1'b0;
            SYSTEM_RESTART_N_OE_OUT <= 1'b1;
            ARM_PERMIT_N_OUT <= 1'b1;
            STANDBY_OUT <= 1'b0;
        end else begin
            SYSTEM_RESTART_N_OUT <= 1'b0; // see [RULE10]
            SYSTEM_RESTART_N_OE_OUT <= (next_state == wdog_pkg::ST_HOLD ||
                next_state == wdog_pkg::ST_FAULT); // see [RULE10]
            ARM_PERMIT_N_OUT <= !(good_count == `SERVICES_TO_PERMIT &&
                next_state != wdog_pkg::ST_HOLD &&
                next_state != wdog_pkg::ST_FAULT); // see [RULE9]
            STANDBY_OUT <= (next_state == wdog_pkg::ST_SLEEP);
        end
    end

    // checks
    low_level_restart_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !level_ok |=> SYSTEM_RESTART_N_OE_OUT) // see [RULE2]
        else $error("restart not driven while level low");
    early_service_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state == wdog_pkg::ST_CLOSED && service) |=> state == wdog_pkg::ST_FAULT
            ##1 SYSTEM_RESTART_N_OE_OUT) // see [RULE4]
        else $error("closed-window service did not restart");
    late_service_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state == wdog_pkg::ST_OPEN && tick && !service && ms_count == OPEN_MS - `MS_W'(1)
            && level_ok && !(SLEEP_VARIANT && quiet_count == QUIET_MS - `MS_W'(1)))
        |=> state == wdog_pkg::ST_FAULT) // see [RULE3]
        else $error("open window expiry did not restart");
    hold_release_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $fell(SYSTEM_RESTART_N_OE_OUT) |-> state == wdog_pkg::ST_CLOSED
            && $past(state) == wdog_pkg::ST_HOLD) // see [RULE1]
        else $error("restart released other than after hold");
    closed_length_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state == wdog_pkg::ST_CLOSED && next_state == wdog_pkg::ST_OPEN)
        |-> phase_cycles == 32'(CLOSED_MS) * 32'(TICK_DIV)) // see [RULE6]
        else $error("closed window wrong length");
    open_length_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state == wdog_pkg::ST_OPEN && next_state == wdog_pkg::ST_FAULT)
        |-> phase_cycles == 32'(OPEN_MS) * 32'(TICK_DIV)) // see [RULE3]
        else $error("open window wrong length");
    permit_count_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $fell(ARM_PERMIT_N_OUT) |-> $past(good_count) == `SERVICES_TO_PERMIT) // see [RULE7]
        else $error("permit before three services");
    fault_clears_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        (state == wdog_pkg::ST_FAULT) |=> good_count == 2'h0 && ARM_PERMIT_N_OUT) // see [RULE11]
        else $error("restart did not clear permit");
    permit_drop_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        SYSTEM_RESTART_N_OE_OUT |-> ARM_PERMIT_N_OUT) // see [RULE11]
        else $error("permit granted during restart");
    drive_low_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        !SYSTEM_RESTART_N_OUT) // see [RULE10]
        else $error("restart pin driven high");
    sleep_variant_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        STANDBY_OUT |-> SLEEP_VARIANT) // see [RULE8]
        else $error("standby in non-sleep variant");
    svc_edge_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        service |-> $past(WINDOW_SERVICE_N_IN, 3)
            && !$past(WINDOW_SERVICE_N_IN, 2)) // see [RULE12]
        else $error("service not on falling edge");

    good_service_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        state == wdog_pkg::ST_OPEN && service);
    permit_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $fell(ARM_PERMIT_N_OUT));
    early_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        state == wdog_pkg::ST_CLOSED && service);
    sleep_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
        $rose(STANDBY_OUT));
endmodule
